// ===== design/lecs_err_counter.sv
`include "lecs_map.svh"
module lecs_err_counter (
   input wire logic aclk,
   input wire logic aresetn,
   lecs_cnt_if.cnt bus
);
   // ========================================================================
   // Eight-bit error counter with terminal-count flag
   // ========================================================================
   logic at_terminal;
   logic near_terminal;
   logic [7:0] next_count;

   // At terminal the hold setting chooses between freezing and wrapping.
   assign at_terminal = (bus.count == `LECS_CNT_TERMINAL);
   assign near_terminal = (bus.count == 8'(`LECS_CNT_TERMINAL - 8'h01));
   assign next_count = at_terminal ? (bus.hold ? bus.count : `LECS_CNT_RESET) : 8'(bus.count + 8'h01); // [R4] [R5]

   // A user clear wins over an error in the same cycle, since software
   // expects a freshly reset counter to read zero.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus.count <= `LECS_CNT_RESET;
         bus.tc <= 1'b0;
         bus.tc_pulse <= 1'b0;
      end else if (bus.clr) begin
         bus.count <= `LECS_CNT_RESET;
         bus.tc <= 1'b0;
         bus.tc_pulse <= 1'b0;
      end else begin
         bus.tc_pulse <= bus.evt & near_terminal;
         if (bus.evt) begin
            bus.count <= next_count;
         end
         if (bus.evt & near_terminal) begin
            bus.tc <= 1'b1; // [R3]
         end
      end
   end
endmodule : lecs_err_counter

// ===== design/lecs_irq_ctrl.sv
`include "lecs_map.svh"
module lecs_irq_ctrl (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [5:0] set_evt,
   input wire logic clr_we,
   input wire logic mask_we,
   input wire logic [5:0] wdata,
   output logic [5:0] status,
   output logic [5:0] mask,
   output logic irq
);
   // ========================================================================
   // Sticky status, mask and level interrupt
   // ========================================================================
   logic [5:0] next_status;
   logic [5:0] next_mask;

   // New events are OR-ed in after the clear, so a set never gets lost.
   assign next_status = (status & ~(clr_we ? wdata : 6'h00)) | set_evt;
   assign next_mask = mask_we ? wdata : mask;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status <= 6'h00;
         mask <= 6'h00;
         irq <= 1'b0;
      end else begin
         status <= next_status;
         mask <= next_mask;
         irq <= |(next_status & next_mask);
      end
   end
endmodule : lecs_irq_ctrl

// ===== design/lecs_status_top.sv
// Operation
// R1: Bit 3 shows whether the lane is enabled.
// R2: Status follows the link chosen by page.
// R3: Terminal flag sets when counter reaches 0xFF.
// R4: Hold set: counter freezes at terminal value.
// R5: Hold clear: counter wraps and keeps counting.
// R6: Flag bits: 2 control-char, 1 table, 0 disparity.
// R7: Lane 3, 4, 5 status at 0x493-0x495.
// R8: Upper four bits read zero; writes ignored.
//
// The AXI4-Lite register port is this design's own decision.
`include "lecs_map.svh"
module lecs_status_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [`LECS_ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [`LECS_ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [17:0] lane_error_events,
   input wire logic [5:0] lane_enabled_in,
   output logic irq
);
   // ========================================================================
   // Address decode
   // ========================================================================
   // Shared by the read and write paths so both agree on the map.
   function automatic lecs_pkg::lecs_sel_t lecs_decode(input logic [11:0] idx);
      lecs_pkg::lecs_sel_t sel;
      sel = lecs_pkg::LECS_SEL_NONE;
      unique case (idx)
         `LECS_IDX_PAGE: sel = lecs_pkg::LECS_SEL_PAGE;
         `LECS_IDX_LANE3: sel = lecs_pkg::LECS_SEL_LANE3; // [R7]
         `LECS_IDX_LANE4: sel = lecs_pkg::LECS_SEL_LANE4; // [R7]
         `LECS_IDX_LANE5: sel = lecs_pkg::LECS_SEL_LANE5; // [R7]
         `LECS_IDX_HOLD: sel = lecs_pkg::LECS_SEL_HOLD;
         `LECS_IDX_CNT_CLR: sel = lecs_pkg::LECS_SEL_CNT_CLR;
         `LECS_IDX_IRQ_STAT: sel = lecs_pkg::LECS_SEL_IRQ_STAT;
         `LECS_IDX_IRQ_MASK: sel = lecs_pkg::LECS_SEL_IRQ_MASK;
         default: sel = lecs_pkg::LECS_SEL_NONE;
      endcase
      return sel;
   endfunction : lecs_decode

   // ========================================================================
   // Control registers and counter bank
   // ========================================================================
   logic page;
   logic [2:0] counter_hold_select;
   logic [5:0] clr_lane;
   logic [17:0] tc_vec;
   logic [5:0] lane_tc_pulse;
   logic [5:0] irq_status;
   logic [5:0] irq_mask;

   lecs_cnt_if cnt_bus [`LECS_NUM_CNT] ();

   // Counter index is link*9 + lane*3 + kind; kind 0 disparity, 1 table,
   // 2 control character, which is also the flag bit order.
   for (genvar lk = 0; lk < `LECS_NUM_LINKS; lk++) begin : g_link
      for (genvar ln = 0; ln < `LECS_NUM_LANES; ln++) begin : g_lane
         for (genvar kd = 0; kd < `LECS_NUM_KINDS; kd++) begin : g_kind
            localparam int C = lk * 9 + ln * 3 + kd;
            assign cnt_bus[C].evt = lane_error_events[C];
            assign cnt_bus[C].clr = clr_lane[lk * 3 + ln];
            assign cnt_bus[C].hold = counter_hold_select[kd]; // [R4] [R5]
            assign tc_vec[C] = cnt_bus[C].tc; // [R6]
            lecs_err_counter u_cnt (
               .aclk(aclk),
               .aresetn(aresetn),
               .bus(cnt_bus[C].cnt)
            );
         end
         assign lane_tc_pulse[lk * 3 + ln] = cnt_bus[lk * 9 + ln * 3].tc_pulse
            | cnt_bus[lk * 9 + ln * 3 + 1].tc_pulse | cnt_bus[lk * 9 + ln * 3 + 2].tc_pulse;
      end
   end

   // ========================================================================
   // Paged lane status views
   // ========================================================================
   logic [7:0] lane_view [`LECS_NUM_LANES];
   for (genvar ln = 0; ln < `LECS_NUM_LANES; ln++) begin : g_view
      logic en_sel;
      logic [2:0] tc_sel;
      assign en_sel = page ? lane_enabled_in[3 + ln] : lane_enabled_in[ln]; // [R1] [R2]
      assign tc_sel = page ? tc_vec[9 + ln * 3 +: 3] : tc_vec[ln * 3 +: 3]; // [R2] [R6]
      assign lane_view[ln] = {`LECS_RSV_ZERO, en_sel, tc_sel}; // [R8]
   end

   // ========================================================================
   // Write channel
   // ========================================================================
   logic aw_full;
   logic w_full;
   logic [11:0] aw_idx;
   logic [7:0] w_byte;
   logic w_lane0;
   logic aw_take;
   logic w_take;
   logic do_write;
   logic next_aw_full;
   logic next_w_full;
   logic next_bvalid;
   lecs_pkg::lecs_sel_t wr_sel;
   logic wr_page;
   logic wr_hold;
   logic wr_clr;
   logic wr_istat;
   logic wr_imask;

   // Address and data are taken in either order and held until both are in.
   assign aw_take = awvalid & awready;
   assign w_take = wvalid & wready;
   assign do_write = aw_full & w_full & ~bvalid;
   assign next_aw_full = (aw_full & ~do_write) | aw_take;
   assign next_w_full = (w_full & ~do_write) | w_take;
   assign next_bvalid = do_write | (bvalid & ~bready);

   // Only byte lane 0 carries register bits; a write without it is a no-op.
   assign wr_sel = lecs_decode(aw_idx);
   assign wr_page = do_write & w_lane0 & (wr_sel == lecs_pkg::LECS_SEL_PAGE);
   assign wr_hold = do_write & w_lane0 & (wr_sel == lecs_pkg::LECS_SEL_HOLD);
   assign wr_clr = do_write & w_lane0 & (wr_sel == lecs_pkg::LECS_SEL_CNT_CLR);
   assign wr_istat = do_write & w_lane0 & (wr_sel == lecs_pkg::LECS_SEL_IRQ_STAT);
   assign wr_imask = do_write & w_lane0 & (wr_sel == lecs_pkg::LECS_SEL_IRQ_MASK);

   // Ready drops as soon as a channel is held, so each takes one beat.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `LECS_RESP_OKAY;
         aw_idx <= 12'h000;
         w_byte <= `LECS_BYTE_RESET;
         w_lane0 <= 1'b0;
      end else begin
         aw_full <= next_aw_full;
         w_full <= next_w_full;
         awready <= ~next_aw_full;
         wready <= ~next_w_full;
         bvalid <= next_bvalid;
         if (aw_take) begin
            aw_idx <= awaddr[`LECS_IDX_MSB:`LECS_IDX_LSB];
         end
         if (w_take) begin
            w_byte <= wdata[7:0];
            w_lane0 <= wstrb[0];
         end
         if (do_write) begin
            bresp <= (wr_sel == lecs_pkg::LECS_SEL_NONE) ? `LECS_RESP_SLVERR : `LECS_RESP_OKAY;
         end
      end
   end

   // Lane status registers have no write path, so stores to them fall away.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         page <= 1'b0;
         counter_hold_select <= 3'h0;
         clr_lane <= 6'h00;
      end else begin
         if (wr_page) begin
            page <= w_byte[0]; // [R2]
         end
         if (wr_hold) begin
            counter_hold_select <= w_byte[2:0]; // [R4] [R5]
         end
         clr_lane <= wr_clr ? (page ? {w_byte[2:0], 3'h0} : {3'h0, w_byte[2:0]}) : 6'h00; // [R8]
      end
   end

   // ========================================================================
   // Interrupts
   // ========================================================================
   lecs_irq_ctrl u_irq (
      .aclk(aclk),
      .aresetn(aresetn),
      .set_evt(lane_tc_pulse),
      .clr_we(wr_istat),
      .mask_we(wr_imask),
      .wdata(w_byte[5:0]),
      .status(irq_status),
      .mask(irq_mask),
      .irq(irq)
   );

   // ========================================================================
   // Read channel
   // ========================================================================
   lecs_pkg::lecs_sel_t rd_sel;
   logic [7:0] rd_byte;
   logic ar_take;
   logic next_rvalid;

   assign ar_take = arvalid & arready;
   assign next_rvalid = ar_take | (rvalid & ~rready);
   assign rd_sel = lecs_decode(araddr[`LECS_IDX_MSB:`LECS_IDX_LSB]);

   // Lane status reads sample the live view at the moment of the request.
   assign rd_byte =
      (rd_sel == lecs_pkg::LECS_SEL_PAGE) ? {7'h00, page} :
      (rd_sel == lecs_pkg::LECS_SEL_LANE3) ? lane_view[0] : // [R7]
      (rd_sel == lecs_pkg::LECS_SEL_LANE4) ? lane_view[1] : // [R7]
      (rd_sel == lecs_pkg::LECS_SEL_LANE5) ? lane_view[2] : // [R7]
      (rd_sel == lecs_pkg::LECS_SEL_HOLD) ? {5'h00, counter_hold_select} :
      (rd_sel == lecs_pkg::LECS_SEL_IRQ_STAT) ? {2'h0, irq_status} :
      (rd_sel == lecs_pkg::LECS_SEL_IRQ_MASK) ? {2'h0, irq_mask} :
      `LECS_BYTE_RESET;

   // One read in flight; address ready stays low until the data is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `LECS_RESP_OKAY;
      end else begin
         arready <= ~next_rvalid;
         rvalid <= next_rvalid;
         if (ar_take) begin
            rdata <= {`LECS_WORD_ZERO, rd_byte};
            rresp <= (rd_sel == lecs_pkg::LECS_SEL_NONE) ? `LECS_RESP_SLVERR : `LECS_RESP_OKAY;
         end
      end
   end
endmodule : lecs_status_top

// ===== pkg/lecs_cnt_if.sv
// ==========================================================================
// Control and status of one error counter
// ==========================================================================
interface lecs_cnt_if;
   logic evt;
   logic clr;
   logic hold;
   logic [7:0] count;
   logic tc;
   logic tc_pulse;
   modport ctl (output evt, output clr, output hold, input count, input tc, input tc_pulse);
   modport cnt (input evt, input clr, input hold, output count, output tc, output tc_pulse);
endinterface : lecs_cnt_if

// ===== pkg/lecs_map.svh
`ifndef LECS_MAP_SVH
`define LECS_MAP_SVH
// ==========================================================================
// Bus geometry and register indices
// ==========================================================================
`define LECS_ADDR_W 14
`define LECS_IDX_MSB 13
`define LECS_IDX_LSB 2
`define LECS_IDX_PAGE 12'h300
`define LECS_IDX_LANE3 12'h493
`define LECS_IDX_LANE4 12'h494
`define LECS_IDX_LANE5 12'h495
`define LECS_IDX_HOLD 12'h498
`define LECS_IDX_CNT_CLR 12'h499
`define LECS_IDX_IRQ_STAT 12'h49a
`define LECS_IDX_IRQ_MASK 12'h49b
// ==========================================================================
// Sizes, fields and values
// ==========================================================================
`define LECS_NUM_LINKS 2
`define LECS_NUM_LANES 3
`define LECS_NUM_KINDS 3
`define LECS_NUM_CNT 18
`define LECS_NUM_LSTAT 6
`define LECS_LANE_EN_BIT 3
`define LECS_TC_MSB 2
`define LECS_TC_LSB 0
`define LECS_CNT_TERMINAL 8'hff
`define LECS_CNT_RESET 8'h00
`define LECS_BYTE_RESET 8'h00
`define LECS_WORD_ZERO 24'h000000
`define LECS_RSV_ZERO 4'h0
`define LECS_RESP_OKAY 2'b00
`define LECS_RESP_SLVERR 2'b10
`endif

// ===== pkg/lecs_pkg.sv
// ==========================================================================
// Types shared by the lane error status block
// ==========================================================================
package lecs_pkg;
   // Register selected by an access, decoded from the word index.
   typedef enum logic [3:0] {
      LECS_SEL_NONE = 4'b0000,
      LECS_SEL_PAGE = 4'b0001,
      LECS_SEL_LANE3 = 4'b0010,
      LECS_SEL_LANE4 = 4'b0011,
      LECS_SEL_LANE5 = 4'b0100,
      LECS_SEL_HOLD = 4'b0101,
      LECS_SEL_CNT_CLR = 4'b0110,
      LECS_SEL_IRQ_STAT = 4'b0111,
      LECS_SEL_IRQ_MASK = 4'b1000
   } lecs_sel_t;
endpackage : lecs_pkg

// ===== test/lecs_status_monitor.sv
// ====================
// Pin-level checks
// ====================
`include "lecs_map.svh"
module lecs_status_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [`LECS_ADDR_W-1:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [5:0] lane_enabled_in,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   // Decode the read index so lane and unmapped reads can be told apart.
   wire [11:0] ar_idx = araddr[`LECS_IDX_MSB:`LECS_IDX_LSB];
   wire is_lane = ar_idx >= `LECS_IDX_LANE3 && ar_idx <= `LECS_IDX_LANE5;
   wire is_own = ar_idx >= `LECS_IDX_HOLD && ar_idx <= `LECS_IDX_IRQ_MASK;
   wire is_mapped = is_lane || is_own || ar_idx == `LECS_IDX_PAGE;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence ar_take;
      arvalid && arready;
   endsequence
   sequence lane_ar;
      ar_take ##0 is_lane;
   endsequence
   a_lane_en_high: assert property (lane_ar ##0 lane_enabled_in == 6'h3f |=> rdata[3])
      else $error("enable bit low although every lane is enabled");
   a_lane_en_low: assert property (lane_ar ##0 lane_enabled_in == 6'h00 |=> !rdata[3])
      else $error("enable bit high although no lane is enabled");
   a_lane_upper_zero: assert property (lane_ar |=> rdata[31:4] == 28'h0 && rresp == `LECS_RESP_OKAY)
      else $error("lane read shows upper bits or an error response");
   a_unmapped_read: assert property (ar_take ##0 !is_mapped |=> rdata == 32'h0 && rresp == `LECS_RESP_SLVERR)
      else $error("unmapped read not refused");
   a_read_answer: assert property (ar_take |=> rvalid)
      else $error("read answer late");
   a_read_single: assert property (rvalid && rready |=> !rvalid)
      else $error("read answer repeated");
   a_write_single: assert property (bvalid && bready |=> !bvalid)
      else $error("write answer repeated");
   // Reset must be watched while it is active, so this one is never disabled.
   a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !irq && !rvalid && !bvalid && !arready)
      else $error("outputs not quiet in reset");
endmodule : lecs_status_monitor
bind lecs_status_top lecs_status_monitor mon (.aclk, .aresetn, .araddr, .arvalid, .arready, .rdata, .rresp,
   .rvalid, .rready, .bvalid, .bready, .lane_enabled_in, .irq);

// ===== test/tb_top.sv
`include "lecs_map.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [1:0] ok = `LECS_RESP_OKAY;
   localparam logic [1:0] err = `LECS_RESP_SLVERR;
   localparam logic [5:0] en = 6'b101010;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [`LECS_ADDR_W-1:0] awaddr = '0;
   logic [`LECS_ADDR_W-1:0] araddr = '0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [31:0] wdata = '0;
   logic [17:0] lane_error_events = '0;
   logic [5:0] lane_enabled_in = '0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [2:0] flags;
   int bad_count = 0;
   int n_compared = 0;
   lecs_status_top dut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'h1),
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .lane_error_events, .lane_enabled_in, .irq);
   // ====================
   // Clock and helpers
   // ====================
   // 125 MHz clock.
   initial begin
      forever #4 aclk = ~aclk;
   end
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Address and data are offered together and each is dropped once taken.
   task automatic wr(input int idx, input logic [7:0] d, input logic [1:0] er);
      bit a;
      bit w;
      a = 0;
      w = 0;
      @(posedge aclk);
      awaddr <= 14'(idx * 4);
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(a && w)) begin
         @(posedge aclk);
         if (awready === 1'b1)
            a = 1;
         if (wready === 1'b1)
            w = 1;
         if (a)
            awvalid <= 1'b0;
         if (w)
            wvalid <= 1'b0;
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk({32'h0, bresp}, {32'h0, er});
   endtask : wr
   task automatic rd(input int idx, input logic [7:0] d, input logic [1:0] er);
      @(posedge aclk);
      araddr <= 14'(idx * 4);
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk({rresp, rdata}, {er, 24'h0, d});
   endtask : rd
   // Back-to-back one-cycle error pulses on a single event line.
   task automatic ev(input int b, input int n);
      repeat (n) begin
         @(posedge aclk);
         lane_error_events <= 18'h1 << b;
      end
      @(posedge aclk);
      lane_error_events <= '0;
   endtask : ev
   task automatic complete_run;
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run
   // A hang is cut short well beyond the expected run of about 2000 cycles.
   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      complete_run();
   end
   // ====================
   // Tests
   // ====================
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 3; i++)
         rd(`LECS_IDX_LANE3 + i, 8'h00, ok);
      lane_enabled_in <= 6'h3f;
      rd(`LECS_IDX_LANE5, 8'h08, ok);
      lane_enabled_in <= en;
      $display("reset values done");
      for (int p = 0; p < 2; p++) begin
         wr(`LECS_IDX_PAGE, 8'(p), ok);
         for (int i = 0; i < 3; i++)
            rd(`LECS_IDX_LANE3 + i, {4'h0, en[p * 3 + i], 3'h0}, ok);
      end
      wr(`LECS_IDX_PAGE, 8'h00, ok);
      wr(`LECS_IDX_LANE4, 8'hff, ok);
      rd(`LECS_IDX_LANE4, 8'h08, ok);
      wr(12'h490, 8'h01, err);
      rd(12'h490, 8'h00, err);
      $display("paging and access done");
      flags = 3'h0;
      for (int k = 0; k < 3; k++) begin
         // From zero the 255th event lands the counter on the terminal value.
         ev(k, 254);
         rd(`LECS_IDX_LANE3, {5'h0, flags}, ok);
         ev(k, 1);
         flags[k] = 1'b1;
         rd(`LECS_IDX_LANE3, {5'h0, flags}, ok);
      end
      rd(`LECS_IDX_IRQ_STAT, 8'h01, ok);
      chk({33'h0, irq}, 34'h0);
      wr(`LECS_IDX_IRQ_MASK, 8'h01, ok);
      @(posedge aclk);
      chk({33'h0, irq}, 34'h1);
      wr(`LECS_IDX_IRQ_STAT, 8'h01, ok);
      @(posedge aclk);
      chk({33'h0, irq}, 34'h0);
      $display("terminal flags and interrupt done");
      ev(0, 255);
      rd(`LECS_IDX_IRQ_STAT, 8'h00, ok);
      ev(0, 1);
      rd(`LECS_IDX_IRQ_STAT, 8'h01, ok);
      wr(`LECS_IDX_IRQ_STAT, 8'h01, ok);
      wr(`LECS_IDX_HOLD, 8'h01, ok);
      ev(0, 300);
      rd(`LECS_IDX_IRQ_STAT, 8'h00, ok);
      rd(`LECS_IDX_LANE3, 8'h07, ok);
      $display("wrap and hold done");
      wr(`LECS_IDX_CNT_CLR, 8'h01, ok);
      rd(`LECS_IDX_LANE3, 8'h00, ok);
      ev(9, 256);
      rd(`LECS_IDX_LANE3, 8'h00, ok);
      wr(`LECS_IDX_PAGE, 8'h01, ok);
      rd(`LECS_IDX_LANE3, 8'h09, ok);
      rd(`LECS_IDX_IRQ_STAT, 8'h08, ok);
      $display("second link done");
      complete_run();
   end
endmodule : tb_top
